// >>> design/nsp_defs.svh
/*
  nsp_defs.svh : offsets, codes, counts and field positions of the navigation
  subframe word packer, as macros.
  assumes: included by bare name after the package, only by design files.
*/
`ifndef NSP_DEFS_SVH
`define NSP_DEFS_SVH

// ****************************************
// register offsets (word addresses)
// ****************************************
`define NSP_OFS_CTRL      4'h0
`define NSP_OFS_STATUS    4'h1
`define NSP_OFS_DROPS     4'h2
`define NSP_OFS_SENT      4'h3

// ****************************************
// control fields and reset values
// ****************************************
`define NSP_CTRL_EN_BIT   0
`define NSP_CTRL_RST      32'h0000_0001

// ****************************************
// constellation codes
// ****************************************
`define NSP_GNSS_GPS      8'h00
`define NSP_GNSS_GAL      8'h02
`define NSP_GNSS_BDS      8'h03
`define NSP_GNSS_QZS      8'h05
`define NSP_GNSS_GLO      8'h06

// ****************************************
// word counts and special values
// ****************************************
`define NSP_WORDS_TEN     4'ha
`define NSP_WORDS_GAL     4'h8
`define NSP_WORDS_GLO     4'h4
`define NSP_SV_UNKNOWN    8'hff
`define NSP_GAL_ALERT     2'h1

// ****************************************
// glonass string fields
// ****************************************
`define NSP_GLO_BITS      85
`define NSP_GLO_HAM_LSB   0
`define NSP_GLO_STR_LSB   80

`endif

// >>> design/nsp_packer.sv
/*
  nsp_packer.sv : navigation subframe word packer with its output fifo.
  a decoded subframe (up to ten raw words, a mode and ids) is taken on a
  one-cycle strobe, checked, formatted and streamed as header + payload.
  assumes: decoder upstream gives the parity result, the inversion flag and raw
  bits on subframe strobe; host drains the stream with valid/ready.
*/
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "nsp_defs.svh"

// ****************************************
// stream fifo
// ****************************************
module nsp_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];    // storage
  logic [AW:0]      wr_reg;         // write pointer, extra wrap bit
  logic [AW:0]      rd_reg;         // read pointer, extra wrap bit
  logic             push;
  logic             pop;

  assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data  = mem[rd_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset: only pointers decide what is valid
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_reg[AW-1:0]] <= in_data;
  end

  // pointers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule : nsp_fifo

// ****************************************
// packer top
// ****************************************
// Notes on behaviour
// [RL1] glonass 85 bits span payload words 0..2
// [RL2] hamming bits 1-8, string 81-84, idle 85
// [RL3] word 3 holds frame/superframe, unknown as zero
// [RL4] unidentified glonass satellite reported as 255
// [RL5] beidou subframe is ten words, arrival order
// [RL6] beidou 30-bit words right aligned, top pad
// [RL7] galileo page pair packed in eight words
// [RL8] galileo alert pages carry page type one
// [RL9] qzss formatted exactly like gps
// [RL10] constellation codes gps0 gal2 bds3 qzs5 glo6
// [RL11] signal codes per constellation table
// [RL12] word count 10, 8 galileo, 4 glonass
// [RL13] nominal subframe intervals set by source rate
// [RL14] emit only complete, parity-passed subframes
// [RL15] inverted data corrected before output
// [RL16] reader ignores pad fields
// [RL17] header carries codes and count before payload
module nsp_packer #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  // decoder side
  input  wire logic          sf_valid,     // one-cycle subframe strobe
  input  wire logic [7:0]    sf_gnss,      // constellation code
  input  wire logic [7:0]    sf_signal,    // signal code
  input  wire logic [7:0]    sf_sv,        // satellite number
  input  wire logic          sf_sv_known,  // satellite identified
  input  wire logic          sf_complete,  // whole subframe seen
  input  wire logic          sf_parity_ok, // every parity check passed
  input  wire logic          sf_invert,    // data needs inversion
  input  wire logic          sf_alert,     // galileo alert page pair
  input  wire logic [319:0]  sf_raw,       // raw words, word 0 low
  input  wire logic [84:0]   sf_glo_string,// glonass string, bit 1 at lsb
  input  wire logic [15:0]   sf_glo_frame, // deduced frame, 0 if unknown
  input  wire logic [15:0]   sf_glo_sframe,// deduced superframe, 0 if unknown
  output logic               sf_busy,      // packer cannot take a subframe
  // host stream
  output logic [33:0]        out_data,     // {first,last,data}
  output logic               out_valid,
  input  wire logic          out_ready,
  // register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata
);
  logic               rs1_reg;          // reset release stage 1
  logic               rst_sync_n;       // released reset
  logic [31:0]        ctrl_reg;         // control, bit 0 enable
  logic [31:0]        drops_reg;        // rejected subframes
  logic [31:0]        sent_reg;         // emitted messages
  logic [31:0]        words_reg [10];   // formatted payload
  nsp_pkg::nsp_header_t hdr_reg;        // pending header
  nsp_pkg::nsp_state_t  state_reg;      // sequencer
  logic [3:0]         idx_reg;          // payload index
  logic [33:0]        f_in;             // fifo input
  logic               f_valid;
  logic               f_ready;
  logic [33:0]        f_out;
  logic               f_out_valid;
  logic               accept;           // subframe taken
  logic               reject;           // subframe refused
  logic [319:0]       fixed;            // raw after inversion

  // word count per constellation
  function automatic logic [3:0] word_count(input logic [7:0] g);
    case (g)
      `NSP_GNSS_GAL: word_count = `NSP_WORDS_GAL; // [RL12]
      `NSP_GNSS_GLO: word_count = `NSP_WORDS_GLO; // [RL12]
      default:       word_count = `NSP_WORDS_TEN; // [RL12] [RL9]
    endcase
  endfunction : word_count

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1_reg    <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rs1_reg    <= 1'b1;
      rst_sync_n <= rs1_reg;
    end
  end

  // taken only when idle; a strobe while busy counts as a drop
  assign fixed  = sf_invert ? ~sf_raw : sf_raw; // [RL15]
  assign accept = sf_valid && ctrl_reg[`NSP_CTRL_EN_BIT] && state_reg == nsp_pkg::NSP_IDLE
                  && sf_complete && sf_parity_ok; // [RL14]
  assign reject = sf_valid && !accept;

  // payload formatting, latched at acceptance
  always_ff @(posedge clk)
  begin
    if (accept)
    begin
      for (int i = 0; i < 10; i++)
      begin
        if (sf_gnss == `NSP_GNSS_BDS)
          words_reg[i] <= {2'h0, fixed[i*32 +: 30]}; // [RL5] [RL6]
        else
          words_reg[i] <= fixed[i*32 +: 32]; // [RL7] [RL9]
      end
      if (sf_gnss == `NSP_GNSS_GAL && sf_alert)
      begin
        // page type pair sits in bits 29:28 of words 0 and 4
        words_reg[0][29:28] <= `NSP_GAL_ALERT; // [RL8]
        words_reg[4][29:28] <= `NSP_GAL_ALERT; // [RL8]
      end
      if (sf_gnss == `NSP_GNSS_GLO)
      begin
        // string bit 85 is msb of word 0; hamming/string number keep place
        words_reg[0] <= sf_glo_string[84:53]; // [RL1] [RL2]
        words_reg[1] <= sf_glo_string[52:21]; // [RL1] [RL2]
        words_reg[2] <= {sf_glo_string[20:0], 11'h000}; // [RL1] [RL2]
        words_reg[3] <= {sf_glo_sframe, sf_glo_frame}; // [RL3]
      end
    end
  end

  // header and sequencing
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_reg <= nsp_pkg::NSP_IDLE;
      idx_reg   <= 4'h0;
      hdr_reg   <= '0;
    end
    else
    begin
      case (state_reg)
        nsp_pkg::NSP_IDLE:
        begin
          if (accept)
          begin
            hdr_reg.gnss_code   <= sf_gnss; // [RL10]
            hdr_reg.signal_code <= sf_signal; // [RL11]
            hdr_reg.sv_number   <= (sf_gnss == `NSP_GNSS_GLO && !sf_sv_known)
                                   ? `NSP_SV_UNKNOWN : sf_sv; // [RL4]
            hdr_reg.payload_word_count <= {4'h0, word_count(sf_gnss)}; // [RL12]
            idx_reg   <= 4'h0;
            state_reg <= nsp_pkg::NSP_HEAD;
          end
        end
        nsp_pkg::NSP_HEAD:
          if (f_ready)
            state_reg <= nsp_pkg::NSP_BODY; // [RL17]
        nsp_pkg::NSP_BODY:
          if (f_ready)
          begin
            idx_reg <= idx_reg + 4'h1;
            if (idx_reg == hdr_reg.payload_word_count[3:0] - 4'h1)
              state_reg <= nsp_pkg::NSP_IDLE;
          end
        default:
          state_reg <= nsp_pkg::NSP_IDLE;
      endcase
    end
  end

  // beat toward the fifo; back-pressure stalls the sequencer
  always_comb
  begin
    f_valid = state_reg != nsp_pkg::NSP_IDLE;
    if (state_reg == nsp_pkg::NSP_HEAD)
      f_in = {1'b1, 1'b0, hdr_reg}; // [RL17]
    else
      f_in = {1'b0, idx_reg == hdr_reg.payload_word_count[3:0] - 4'h1,
              words_reg[idx_reg]};
  end

  nsp_fifo #(
    .WIDTH (34),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_sync_n),
    .in_data   (f_in),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (!out_valid || out_ready)
  );

  // output register slice; keeps outputs straight from flops
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (!out_valid || out_ready)
    begin
      out_valid <= f_out_valid;
      out_data  <= f_out;
    end
  end
  // note: fifo pops exactly when the slice reloads, so an empty slice
  // taking a word never leaves a copy of it behind in the fifo

  // busy flag for the decoder
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      sf_busy <= 1'b1;
    else
      sf_busy <= !(state_reg == nsp_pkg::NSP_IDLE && !accept);
  end

  // registers: control and counters
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl_reg  <= `NSP_CTRL_RST;
      drops_reg <= '0;
      sent_reg  <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == `NSP_OFS_CTRL)
        ctrl_reg <= {31'h0, reg_wdata[`NSP_CTRL_EN_BIT]};
      // counting beats writes: a clear write loses to a new event
      if (reject)
        drops_reg <= drops_reg + 32'h1;
      else if (reg_wr && reg_addr == `NSP_OFS_DROPS)
        drops_reg <= '0;
      // one message per taken subframe: message rate follows the source's rate
      if (state_reg == nsp_pkg::NSP_HEAD && f_ready) // [RL13]
        sent_reg <= sent_reg + 32'h1;
      else if (reg_wr && reg_addr == `NSP_OFS_SENT)
        sent_reg <= '0;
    end
  end

  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      reg_rdata <= '0;
    else if (reg_rd)
      case (reg_addr)
        `NSP_OFS_CTRL:   reg_rdata <= ctrl_reg;
        `NSP_OFS_STATUS: reg_rdata <= {28'h0, f_out_valid, !f_ready,
                                       state_reg};
        `NSP_OFS_DROPS:  reg_rdata <= drops_reg;
        `NSP_OFS_SENT:   reg_rdata <= sent_reg;
        default:         reg_rdata <= '0;
      endcase
    else
      reg_rdata <= '0;
  end
endmodule : nsp_packer

// >>> design/nsp_pkg.sv
/*
  nsp_pkg.sv : types of the packer, which uses the header and state types; the fifo uses none of them.
  assumes: nothing; every user writes nsp_pkg::name.
*/
package nsp_pkg;

  // message header word, ahead of the payload words
  typedef struct packed {
    logic [7:0] gnss_code;          // constellation code
    logic [7:0] signal_code;        // signal code
    logic [7:0] sv_number;          // satellite number, 255 unknown glonass
    logic [7:0] payload_word_count; // words that follow
  } nsp_header_t;

  // one word on the output stream
  typedef struct packed {
    logic        first;             // header word
    logic        last;              // final payload word
    logic [31:0] data;              // header or payload
  } nsp_beat_t;

  // packer states
  typedef enum logic [1:0] {
    NSP_IDLE,
    NSP_HEAD,
    NSP_BODY
  } nsp_state_t;

endpackage : nsp_pkg

// >>> dv/nsp_host_model.sv
/*
  nsp_host_model.sv : host that drains the packed message stream.
  assumes: one clock; beats are {first,last,data}, header first.
*/
`timescale 1ns/100ps
// ****************************************
// host reader
// ****************************************
module nsp_host_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [33:0] out_data,
  input  wire logic        out_valid,
  input  wire logic        hold,       // stop draining
  output logic             out_ready,
  output logic             got,        // beat taken at this edge
  output logic [33:0]      beat        // beat as the reader keeps it
);
  logic bds_reg; // message in flight is beidou
  // random stalls, so the fifo sees back-pressure
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      out_ready <= 1'b0;
    else
      out_ready <= !hold && ($urandom % 4 != 0);
  // constellation is known only from the header
  always_ff @(posedge clk)
    if (got && out_data[33])
      bds_reg <= (out_data[31:24] == 8'h03);
  assign got = out_valid && out_ready;
  // pad bits mean nothing to the reader, so they are cleared here
  assign beat = (bds_reg && !out_data[33]) ?
                {out_data[33:32], 2'b00, out_data[29:0]} : out_data;
endmodule : nsp_host_model

// >>> dv/nsp_packer_assertions.sv
/*
  nsp_packer_assertions.sv : port checker of nsp_packer, bound at the foot.
  assumes: one clock domain, rst_n active low.
*/
`timescale 1ns/100ps
// ****************************************
// checker
// ****************************************
module nsp_packer_checker #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        sf_valid,
  input wire logic        sf_complete,
  input wire logic        sf_parity_ok,
  input wire logic        sf_busy,
  input wire logic [33:0] out_data,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr
);
  logic       en_reg;   // enable as last written
  logic       msg_reg;  // payload still to come
  logic [7:0] gnss_reg; // constellation in flight
  logic [7:0] cnt_reg;  // words announced
  logic [7:0] idx_reg;  // payload words taken
  logic       hs;       // stream handshake
  assign hs = out_valid && out_ready;
  // mirror of the enable bit
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      en_reg <= 1'b1;
    else if (reg_wr && reg_addr == 4'h0)
      en_reg <= reg_wdata[0];
  // position inside the message
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      msg_reg <= 1'b0;
      idx_reg <= 8'h00;
    end
    else if (hs)
    begin
      msg_reg <= !out_data[32];
      idx_reg <= out_data[33] ? 8'h00 : idx_reg + 8'h01;
    end
  // header fields kept for the payload checks
  always_ff @(posedge clk)
    if (hs && out_data[33])
    begin
      gnss_reg <= out_data[31:24];
      cnt_reg  <= out_data[7:0];
    end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_HDR_SOON:
    assert property (sf_valid && !sf_busy && sf_complete && sf_parity_ok && en_reg
      |-> ##[1:200] out_valid && out_data[33]) else $error("no header");
  AST_BAD_IDLE:
    assert property (sf_valid && !sf_busy && !(sf_complete && sf_parity_ok) |=> !sf_busy)
      else $error("bad subframe taken");
  AST_BUSY_CAUSE:
    assert property ($rose(sf_busy) |-> $past(sf_valid && sf_complete && sf_parity_ok))
      else $error("busy without good subframe");
  AST_HOLD:
    assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("beat dropped");
  AST_COUNT:
    assert property (out_valid && out_data[33] |-> out_data[7:0] == (out_data[31:24] == 8'h02
      ? 8'h08 : out_data[31:24] == 8'h06 ? 8'h04 : 8'h0a)) else $error("bad count");
  AST_BDS_PAD:
    assert property (out_valid && msg_reg && gnss_reg == 8'h03 |-> out_data[31:30] == 2'b00)
      else $error("pad set");
  AST_LAST:
    assert property (out_valid && msg_reg |-> !out_data[33]
      && out_data[32] == (idx_reg == cnt_reg - 8'h01)) else $error("bad last");
  AST_HDR_FIRST:
    assert property (out_valid && !msg_reg |-> out_data[33]) else $error("no header first");
  AST_GLO_FILL:
    assert property (out_valid && msg_reg && gnss_reg == 8'h06 && idx_reg == 8'h02
      |-> out_data[10:0] == 11'h000) else $error("glonass fill");
  cover property (hs && out_data[33] && out_data[31:24] == 8'h06);
  cover property (sf_valid && !sf_busy && !sf_parity_ok);
  cover property ((out_valid && !out_ready) [*4]);
endmodule : nsp_packer_checker

bind nsp_packer nsp_packer_checker #(.FIFO_DEPTH(FIFO_DEPTH)) nsp_packer_checker_inst (
  .clk, .rst_n, .sf_valid, .sf_complete, .sf_parity_ok, .sf_busy, .out_data,
  .out_valid, .out_ready, .reg_addr, .reg_wdata, .reg_wr);

// >>> dv/tb.sv
/*
  tb.sv : self-checking bench of nsp_packer with the host model.
  assumes: design files and checker compiled before it.
*/
`timescale 1ns/100ps
`define CHK(nm, e, s) begin tests_run++; if ((e) !== (s)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", nm, e, s); end end
module tb;
  logic        clk, rst_n, sf_valid, sf_sv_known, sf_complete, sf_parity_ok;
  logic        sf_invert, sf_alert, sf_busy, out_valid, out_ready, reg_wr, reg_rd;
  logic        hold, got;
  logic [7:0]  sf_gnss, sf_signal, sf_sv;
  logic [319:0] sf_raw;
  logic [84:0] sf_glo_string;
  logic [15:0] sf_glo_frame, sf_glo_sframe;
  logic [33:0] out_data, beat, e_now;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [33:0] exp_q [$];   // expected beats, oldest first
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          n;
  logic [15:0] codes [16] = '{16'h0000, 16'h0003, 16'h0004, 16'h0200, 16'h0201, 16'h0205,
    16'h0206, 16'h0300, 16'h0301, 16'h0302, 16'h0303, 16'h0500, 16'h0504, 16'h0505,
    16'h0600, 16'h0602};
  nsp_packer #(.FIFO_DEPTH(16)) nsp_packer_inst (.clk, .rst_n, .sf_valid, .sf_gnss,
    .sf_signal, .sf_sv, .sf_sv_known, .sf_complete, .sf_parity_ok, .sf_invert, .sf_alert,
    .sf_raw, .sf_glo_string, .sf_glo_frame, .sf_glo_sframe, .sf_busy, .out_data,
    .out_valid, .out_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  nsp_host_model nsp_host_model_inst (.clk, .rst_n, .out_data, .out_valid, .hold,
    .out_ready, .got, .beat);
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // read data stand only in the cycle after the strobe
  task automatic reg_check(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask : reg_check
  // offer one subframe; cp is {complete, parity_ok}, expectations noted if taken
  task automatic send(input logic [15:0] gs, input logic [1:0] cp, input logic take);
    logic [319:0] raw;
    logic [127:0] glo;
    logic [31:0]  w;
    logic [7:0]   sv, c, g;
    logic         known, alert, inv;
    int           t;
    t = 0;
    @(negedge clk);
    while (sf_busy !== 1'b0 && t < 2000)
    begin
      @(negedge clk);
      t++;
    end
    if (t == 2000)
    begin
      n_mismatch++;
      report_and_stop;
    end
    g = gs[15:8];
    for (int i = 0; i < 10; i++)
      raw[32*i +: 32] = $urandom;
    glo = {$urandom, $urandom, $urandom, $urandom};
    glo[42:32] = 11'h000;
    sv = $urandom;
    known = $urandom;
    alert = (g == 8'h02) && ($urandom % 2);
    inv = (g == 8'h00 || g == 8'h05) && ($urandom % 2);
    @(posedge clk);
    {sf_gnss, sf_signal, sf_sv, sf_sv_known, sf_alert, sf_invert} <= {gs, sv, known, alert, inv};
    {sf_complete, sf_parity_ok, sf_raw} <= {cp, raw};
    {sf_glo_string, sf_glo_sframe, sf_glo_frame} <= {glo[127:43], glo[31:0]};
    sf_valid <= 1'b1;
    @(posedge clk);
    sf_valid <= 1'b0;
    if (take)
    begin
      c = (g == 8'h02) ? 8'h08 : (g == 8'h06) ? 8'h04 : 8'h0a;
      exp_q.push_back({2'b10, gs, (g == 8'h06 && !known) ? 8'hff : sv, c});
      for (int i = 0; i < c; i++)
      begin
        w = raw[32*i +: 32] ^ {32{inv}};
        if (g == 8'h03)
          w[31:30] = 2'b00;
        if (alert && (i == 0 || i == 4))
          w[29:28] = 2'b01;
        if (g == 8'h06)
          w = glo[127-32*i -: 32];
        exp_q.push_back({1'b0, i == c - 8'h01, w});
      end
    end
  endtask : send
  // oldest note against each beat the host takes
  always @(posedge clk)
    if (rst_n === 1'b1 && got === 1'b1)
    begin
      e_now = exp_q.size() ? exp_q.pop_front() : 'x;
      `CHK("beat", e_now, beat)
    end
  initial
  begin
    {rst_n, sf_valid, sf_gnss, sf_signal, sf_sv, sf_sv_known, sf_complete} = '0;
    {sf_parity_ok, sf_invert, sf_alert, sf_raw, sf_glo_string} = '0;
    {sf_glo_frame, sf_glo_sframe, reg_addr, reg_wdata, reg_wr, reg_rd, hold} = '0;
    void'($urandom(7363));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // the internal reset copy is released two edges later
    repeat (3) @(posedge clk);
    reg_check(4'h0, 32'h0000_0001);
    reg_check(4'h2, 32'h0000_0000);
    reg_check(4'hf, 32'h0000_0000);
    @(posedge clk) hold <= 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      send(codes[k], 2'b11, 1'b1);
      if (k == 1)
      begin
        repeat (40) @(posedge clk);
        reg_check(4'h1, 32'h0000_000e);
        @(posedge clk) hold <= 1'b0;
      end
    end
    send(codes[15], 2'b10, 1'b0);
    send(codes[0], 2'b01, 1'b0);
    reg_write(4'h0, 32'h0000_0000);
    send(codes[7], 2'b11, 1'b0);
    reg_write(4'h0, 32'h0000_0001);
    send(codes[7], 2'b11, 1'b1);
    n = 0;
    while (exp_q.size() != 0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("pending", 0, exp_q.size())
    reg_check(4'h2, 32'h0000_0003);
    reg_check(4'h3, 32'h0000_0011);
    reg_write(4'h2, 32'h0000_0000);
    reg_check(4'h2, 32'h0000_0000);
    report_and_stop;
  end
endmodule : tb
